// file: bench/mmxa_memory_map_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mmxa_memory_map_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // program space
  input wire logic [4:0] vectorIndex,
  input wire logic [15:0] fetchPc,
  input wire logic codeMove,
  input wire logic [7:0] accumulator,
  input wire logic [15:0] resetPc,
  input wire logic [15:0] vectorAddr,
  input wire logic [14:0] codeAddr,
  input wire logic [15:0] jumpTarget,
  // internal data access
  input wire logic dataReq,
  input wire logic dataWe,
  input wire mmxa_pkg::mmxa_mode_t dataMode,
  input wire logic [7:0] dataAddr,
  input wire logic dataRvalid,
  // outer special registers
  input wire logic sfrReq,
  input wire logic [7:0] sfrAddr,
  // pointers and external moves
  input wire logic pointerIncrement,
  input wire logic pointerLoad,
  input wire logic [15:0] pointerLoadValue,
  input wire logic xReq,
  input wire logic xWe,
  input wire logic xPagedForm,
  input wire logic xRvalid,
  input wire logic [7:0] xRdata,
  input wire logic [15:0] dataPointer,
  input wire logic [2:0] pageSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic [15:0] idxSum = dataPointer + {8'h00, accumulator};
  wire logic localReg = dataAddr inside {8'h82, 8'h83, 8'h8F, 8'hA2};
  wire logic xOut = xPagedForm ? (pageSelect == 3'h7) : (dataPointer > 16'h06FF);

  reset_entry_a: assert property (resetPc == 16'h0000)
    else $error("reset entry not zero");
  vector_slot_a: assert property (vectorAddr == 16'h0003 + {8'h00, vectorIndex, 3'b000})
    else $error("vector slot wrong");
  direct_upper_a: assert property (dataReq && dataMode == mmxa_pkg::MODE_DIRECT && dataAddr[7]
    && !localReg |-> sfrReq && sfrAddr == dataAddr) else $error("direct upper missed registers");
  indirect_ram_a: assert property (dataReq && dataMode == mmxa_pkg::MODE_INDIRECT |-> !sfrReq)
    else $error("indirect reached registers");
  read_answer_a: assert property (dataReq && !dataWe |=> dataRvalid)
    else $error("no data answer");
  move_answer_a: assert property (xReq && !xWe |=> xRvalid)
    else $error("no move answer");
  move_range_a: assert property (xReq && !xWe && xOut |=> xRdata == 8'hFF)
    else $error("out of range read not constant");
  code_read_a: assert property (codeAddr == (codeMove ? idxSum[14:0] : fetchPc[14:0]))
    else $error("code address wrong");
  jump_target_a: assert property (jumpTarget == idxSum)
    else $error("jump target wrong");
  pointer_step_a: assert property (pointerIncrement && !pointerLoad && !dataReq
    |=> dataPointer == $past(dataPointer) + 16'h0001) else $error("pointer step wrong");
  pointer_load_a: assert property (pointerLoad && !dataReq |=> dataPointer == $past(pointerLoadValue))
    else $error("pointer load wrong");
endmodule
bind mmxa_memory_map mmxa_memory_map_asserts chk_u (.*);
`default_nettype wire

// file: bench/mmxa_sfr_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmxa_sfr_model (
  // clock
  input wire logic clk,
  // register bus from the block
  input wire logic sfrReq,
  input wire logic sfrWe,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata
);
  logic [7:0] regs [128];
  // idle bus shows a moving pattern, not the last value
  assign sfrRdata = sfrReq ? regs[sfrAddr[6:0]] : ~sfrAddr;
  always_ff @(posedge clk) begin
    if (sfrReq && sfrWe) begin
      regs[sfrAddr[6:0]] <= sfrWdata;
    end
  end
endmodule
`default_nettype wire

// file: bench/test_memory_map_expanded_ram_access.sv
`timescale 1ns/1ps
`default_nettype none
module test_memory_map_expanded_ram_access;
  localparam mmxa_pkg::mmxa_mode_t MD = mmxa_pkg::MODE_DIRECT;
  localparam mmxa_pkg::mmxa_mode_t MI = mmxa_pkg::MODE_INDIRECT;
  localparam mmxa_pkg::mmxa_mode_t MR = mmxa_pkg::MODE_REGISTER;
  localparam mmxa_pkg::mmxa_mode_t MB = mmxa_pkg::MODE_BIT;
  logic clk, rst_n, codeMove, dataReq, dataWe, dataBitValue, dataRvalid, dataRbit;
  logic sfrReq, sfrWe, pointerIncrement, pointerLoad, xReq, xWe, xPagedForm, xRvalid;
  logic pointerSelectBit;
  logic [1:0] bankSelect;
  logic [2:0] pageSelect, pg;
  logic [4:0] vectorIndex;
  logic [7:0] accumulator, dataAddr, dataWdata, dataRdata, sfrAddr, sfrWdata, sfrRdata;
  logic [7:0] xLowByte, xWdata, xRdata, v;
  logic [14:0] codeAddr;
  logic [15:0] fetchPc, resetPc, vectorAddr, jumpTarget, pointerLoadValue, dataPointer, seed;
  mmxa_pkg::mmxa_mode_t dataMode;
  int numErrors, nChecks;

  mmxa_memory_map dut_u (.*);
  mmxa_sfr_model sfr_u (.*);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, exp, input string what);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] vecAt(input int i);
    return 16'h0003 + 16'(8 * i);
  endfunction
  task automatic dacc(input mmxa_pkg::mmxa_mode_t m, input logic we, input logic [7:0] a, d);
    @(negedge clk);
    dataReq = 1'b1;
    dataWe = we;
    dataMode = m;
    dataAddr = a;
    dataWdata = d;
    @(negedge clk);
    dataReq = 1'b0;
  endtask
  task automatic drd(input mmxa_pkg::mmxa_mode_t m, input logic [7:0] a, exp);
    dacc(m, 1'b0, a, 8'h00);
    chk(16'(dataRvalid), 16'h0001, "data valid");
    chk(16'(dataRdata), 16'(exp), "data read");
  endtask
  task automatic xacc(input logic we, paged, input logic [7:0] lo, d);
    @(negedge clk);
    xReq = 1'b1;
    xWe = we;
    xPagedForm = paged;
    xLowByte = lo;
    xWdata = d;
    @(negedge clk);
    xReq = 1'b0;
  endtask
  task automatic xrd(input logic [7:0] exp);
    xacc(1'b0, 1'b0, 8'h00, 8'h00);
    chk(16'(xRvalid), 16'h0001, "move valid");
    chk(16'(xRdata), 16'(exp), "move read");
  endtask
  task automatic ptr(input logic ld, input logic [15:0] val);
    @(negedge clk);
    pointerLoad = ld;
    pointerIncrement = !ld;
    pointerLoadValue = val;
    @(negedge clk);
    pointerLoad = 1'b0;
    pointerIncrement = 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #60000;
    numErrors++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    {rst_n, codeMove, dataReq, dataWe, dataBitValue, pointerIncrement, pointerLoad} = '0;
    {xReq, xWe, xPagedForm, bankSelect, vectorIndex, accumulator, dataAddr} = '0;
    {dataWdata, xLowByte, xWdata, fetchPc, pointerLoadValue} = '0;
    dataMode = MD;
    seed = 16'h84C5;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(resetPc, 16'h0000, "reset entry");
    chk(16'(pointerSelectBit), 16'h0000, "select reset");
    drd(MD, mmxa_pkg::AUXILIARY_POINTER_CONTROL, 8'h00);
    for (int i = 0; i < 18; i++) begin
      @(negedge clk);
      vectorIndex = 5'(i);
      #1 chk(vectorAddr, vecAt(i), "vector");
    end
    $display("test reset and vectors done");
    seed = lfsr(seed);
    v = seed[7:0];
    dacc(MI, 1'b1, 8'h90, v);
    dacc(MD, 1'b1, 8'h90, ~v);
    drd(MI, 8'h90, v);
    drd(MD, 8'h90, ~v);
    dataBitValue = 1'b1;
    dacc(MB, 1'b1, 8'h91, 8'h00);
    drd(MD, 8'h90, ~v | 8'h02);
    dacc(MD, 1'b1, 8'h21, 8'h00);
    dacc(MB, 1'b1, 8'h0B, 8'h00);
    drd(MD, 8'h21, 8'h08);
    drd(MB, 8'h0B, 8'h08);
    chk(16'(dataRbit), 16'h0001, "bit read");
    for (int b = 0; b < 4; b++) begin
      bankSelect = 2'(b);
      dacc(MR, 1'b1, 8'h05, 8'(8'hA0 + b));
      drd(MD, 8'(8 * b + 5), 8'(8'hA0 + b));
    end
    $display("test internal data done");
    ptr(1'b1, 16'h0110);
    dacc(MD, 1'b1, mmxa_pkg::AUXILIARY_POINTER_CONTROL, 8'h01);
    chk(16'(pointerSelectBit), 16'h0001, "select set");
    ptr(1'b1, 16'h06FF);
    ptr(1'b0, 16'h0000);
    chk(dataPointer, 16'h0700, "increment");
    drd(MD, mmxa_pkg::DATA_POINTER_LOW_BYTE, 8'h00);
    drd(MD, mmxa_pkg::DATA_POINTER_HIGH_BYTE, 8'h07);
    xacc(1'b1, 1'b0, 8'h00, 8'h3C);
    xrd(8'hFF);
    dacc(MD, 1'b1, mmxa_pkg::AUXILIARY_POINTER_CONTROL, 8'h00);
    chk(dataPointer, 16'h0110, "first pointer kept");
    accumulator = 8'hF0;
    codeMove = 1'b1;
    #1 chk(jumpTarget, 16'h0200, "jump");
    chk({1'b0, codeAddr}, 16'h0200, "code move");
    codeMove = 1'b0;
    fetchPc = 16'h7FFF;
    #1 chk({1'b0, codeAddr}, 16'h7FFF, "fetch");
    $display("test pointers done");
    for (int k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      pg = 3'(seed[10:8] % 3'd7);
      dacc(MD, 1'b1, mmxa_pkg::EXPANDED_RAM_PAGE_SELECT, {5'h00, pg});
      drd(MD, mmxa_pkg::EXPANDED_RAM_PAGE_SELECT, {5'h00, pg});
      chk(16'(pageSelect), 16'(pg), "page select");
      xacc(1'b1, 1'b1, seed[7:0], seed[15:8]);
      ptr(1'b1, {5'h00, pg, seed[7:0]});
      xrd(seed[15:8]);
    end
    ptr(1'b1, 16'h0000);
    xacc(1'b1, 1'b0, 8'h00, 8'h5A);
    ptr(1'b1, 16'h0800);
    xacc(1'b1, 1'b0, 8'h00, 8'hA5);
    xrd(8'hFF);
    ptr(1'b1, 16'h0000);
    xrd(8'h5A);
    dacc(MD, 1'b1, mmxa_pkg::EXPANDED_RAM_PAGE_SELECT, 8'h07);
    chk(16'(pageSelect), 16'h0007, "page seven");
    xacc(1'b0, 1'b1, 8'h00, 8'h00);
    chk(16'(xRdata), 16'h00FF, "page seven read");
    $display("test expanded ram done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: common/mmxa_pkg.sv
// How it works
// RQ1: first fetch after reset at address zero
// RQ2: interrupt vectors fixed, eight bytes apart
// RQ3: direct access above 7FH reaches registers
// RQ4: indirect access above 7FH reaches upper RAM
// RQ5: lowest 32 bytes form four register banks
// RQ6: bit addresses 00H-7FH map bytes 20H-2FH
// RQ7: lower half direct or indirect, upper indirect
// RQ8: special registers reachable only by direct access
// RQ9: registers ending 0H or 8H bit-addressable
// RQ10: 1792-byte expanded RAM by external moves only
// RQ11: no off-chip external data cycles
// RQ12: byte-pointer moves use page-select high byte
// RQ13: two data pointers, one select bit
// RQ14: selected pointer used by all pointer operations
// RQ15: select bit is control bit 0, resets 0
// RQ16: 0x82 low byte, companion high byte
// RQ17: software writes zeros to page-select bits 7-3
// RQ18: page select bits 2-0, upper read zero
// RQ19: paged region shares expanded RAM storage
// RQ20: 32K code read by fetch and code move
// RQ21: two status bits choose working-register bank
// RQ22: moves past expanded RAM ignored, read constant
package mmxa_pkg;

  // ----------------------------------------
  // program space
  // ----------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam int VECTOR_SPACING_LOG2 = 3;
  localparam int CODE_SIZE = 32768;
  localparam int CODE_AW = 15;

  // ----------------------------------------
  // internal data space
  // ----------------------------------------
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [3:0] BIT_AREA_HIGH_NIBBLE = 4'h2;
  localparam logic [2:0] BANK_AREA_TOP = 3'h0;

  // ----------------------------------------
  // special register offsets
  // ----------------------------------------
  localparam logic [7:0] DATA_POINTER_LOW_BYTE = 8'h82;
  localparam logic [7:0] DATA_POINTER_HIGH_BYTE = 8'h83;
  localparam logic [7:0] EXPANDED_RAM_PAGE_SELECT = 8'h8F;
  localparam logic [7:0] AUXILIARY_POINTER_CONTROL = 8'hA2;

  // ----------------------------------------
  // field layouts and reset values
  // ----------------------------------------
  localparam int POINTER_SELECT_BIT = 0;
  localparam logic [7:0] AUX_WRITABLE_MASK = 8'h31;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam int PAGE_BITS = 3;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam logic [15:0] POINTER_RESET = 16'h0000;

  // ----------------------------------------
  // expanded RAM
  // ----------------------------------------
  localparam int EXP_RAM_SIZE = 1792;
  localparam int EXP_RAM_AW = 11;
  localparam logic [7:0] EXP_RAM_FILL = 8'hFF;

  // ----------------------------------------
  // internal access modes
  // ----------------------------------------
  typedef enum logic [3:0] {
    MODE_DIRECT = 4'h1,
    MODE_INDIRECT = 4'h2,
    MODE_REGISTER = 4'h4,
    MODE_BIT = 4'h8
  } mmxa_mode_t;

endpackage

// file: hw/mmxa_memory_map.sv
`timescale 1ns/1ps
`default_nettype none
module mmxa_memory_map #(
  parameter int EXP_RAM_BYTES = mmxa_pkg::EXP_RAM_SIZE,
  parameter int POINTERS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // program space
  input wire logic [4:0] vectorIndex,
  input wire logic [15:0] fetchPc,
  input wire logic codeMove,
  input wire logic [7:0] accumulator,
  output logic [15:0] resetPc,
  output logic [15:0] vectorAddr,
  output logic [14:0] codeAddr,
  output logic [15:0] jumpTarget,
  // internal data access
  input wire logic dataReq,
  input wire logic dataWe,
  input wire mmxa_pkg::mmxa_mode_t dataMode,
  input wire logic [7:0] dataAddr,
  input wire logic [7:0] dataWdata,
  input wire logic dataBitValue,
  input wire logic [1:0] bankSelect,
  output logic dataRvalid,
  output logic [7:0] dataRdata,
  output logic dataRbit,
  // outer special registers
  output logic sfrReq,
  output logic sfrWe,
  output logic [7:0] sfrAddr,
  output logic [7:0] sfrWdata,
  input wire logic [7:0] sfrRdata,
  // data pointer operations
  input wire logic pointerIncrement,
  input wire logic pointerLoad,
  input wire logic [15:0] pointerLoadValue,
  // external moves
  input wire logic xReq,
  input wire logic xWe,
  input wire logic xPagedForm,
  input wire logic [7:0] xLowByte,
  input wire logic [7:0] xWdata,
  output logic xRvalid,
  output logic [7:0] xRdata,
  // state seen by the core
  output logic [15:0] dataPointer,
  output logic pointerSelectBit,
  output logic [2:0] pageSelect
);

  // ----------------------------------------
  // program space addresses
  // ----------------------------------------
  wire [15:0] vectorOffset;
  wire [15:0] pointerPlusAcc;

  assign resetPc = mmxa_pkg::PC_RESET; // see RQ1
  assign vectorOffset = {8'h00, vectorIndex, 3'b000};
  assign vectorAddr = mmxa_pkg::VECTOR_BASE + vectorOffset; // see RQ2
  assign pointerPlusAcc = dataPointer + {8'h00, accumulator}; // see RQ14
  assign jumpTarget = pointerPlusAcc; // see RQ14
  // fetch and code move share the 32K code space
  assign codeAddr = codeMove ? pointerPlusAcc[14:0] : fetchPc[14:0]; // see RQ20

  // ----------------------------------------
  // internal address decode
  // ----------------------------------------
  wire isDirect;
  wire isIndirect;
  wire isRegister;
  wire isBit;
  wire [7:0] bankAddr;
  wire [7:0] bitByteAddr;
  wire [7:0] byteAddr;
  wire [2:0] bitPos;
  wire inUpper;
  wire toSfr;
  wire toRam;

  assign isDirect = (dataMode == mmxa_pkg::MODE_DIRECT);
  assign isIndirect = (dataMode == mmxa_pkg::MODE_INDIRECT);
  assign isRegister = (dataMode == mmxa_pkg::MODE_REGISTER);
  assign isBit = (dataMode == mmxa_pkg::MODE_BIT);

  // register form: bank bits above the register number
  assign bankAddr = {mmxa_pkg::BANK_AREA_TOP, bankSelect, dataAddr[2:0]}; // see RQ5 RQ21

  // bit form: low half maps 20H-2FH, high half maps xxxx_x000 registers
  assign bitByteAddr = dataAddr[7] ? {dataAddr[7:3], 3'b000} // see RQ9
                                   : {mmxa_pkg::BIT_AREA_HIGH_NIBBLE, dataAddr[6:3]}; // see RQ6
  assign bitPos = dataAddr[2:0];

  assign byteAddr = isRegister ? bankAddr : (isBit ? bitByteAddr : dataAddr);
  assign inUpper = (byteAddr >= mmxa_pkg::UPPER_BASE);

  // direct above 7FH is register space, indirect above 7FH is RAM
  assign toSfr = dataReq && inUpper && (isDirect || isBit); // see RQ3 RQ8
  assign toRam = dataReq && !toSfr && (isDirect || isBit || isIndirect || isRegister); // see RQ4 RQ7

  // ----------------------------------------
  // local special registers
  // ----------------------------------------
  wire hitLow;
  wire hitHigh;
  wire hitAux;
  wire hitPage;
  wire hitLocal;
  logic [7:0] auxReg;
  logic [7:0] localRdata;

  assign hitLow = toSfr && (byteAddr == mmxa_pkg::DATA_POINTER_LOW_BYTE);
  assign hitHigh = toSfr && (byteAddr == mmxa_pkg::DATA_POINTER_HIGH_BYTE);
  assign hitAux = toSfr && (byteAddr == mmxa_pkg::AUXILIARY_POINTER_CONTROL);
  assign hitPage = toSfr && (byteAddr == mmxa_pkg::EXPANDED_RAM_PAGE_SELECT);
  assign hitLocal = hitLow || hitHigh || hitAux || hitPage;

  always_comb begin
    localRdata = 8'h00;
    if (hitLow) begin
      localRdata = dataPointer[7:0]; // see RQ16
    end else if (hitHigh) begin
      localRdata = dataPointer[15:8]; // see RQ16
    end else if (hitAux) begin
      localRdata = auxReg;
    end else if (hitPage) begin
      localRdata = {5'b00000, pageSelect}; // see RQ18
    end
  end

  // outer registers get the byte, bit writes folded in here
  assign sfrReq = toSfr && !hitLocal;
  assign sfrWe = sfrReq && dataWe;
  assign sfrAddr = byteAddr;

  // ----------------------------------------
  // internal RAM and byte merge
  // ----------------------------------------
  logic [7:0] iram [0:255];
  wire [7:0] currentByte;
  wire [7:0] bitMask;
  wire [7:0] writeByte;
  wire writeLocal;

  assign currentByte = toSfr ? (hitLocal ? localRdata : sfrRdata) : iram[byteAddr];
  assign bitMask = 8'h01 << bitPos;
  assign writeByte = isBit ? ((currentByte & ~bitMask) | (dataBitValue ? bitMask : 8'h00))
                           : dataWdata;
  assign writeLocal = hitLocal && dataWe;
  assign sfrWdata = writeByte;

  always_ff @(posedge clk) begin
    if (toRam && dataWe) begin
      iram[byteAddr] <= writeByte; // see RQ4 RQ7
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataRvalid <= 1'b0;
      dataRdata <= 8'h00;
      dataRbit <= 1'b0;
    end else begin
      dataRvalid <= dataReq && !dataWe;
      if (dataReq && !dataWe) begin
        dataRdata <= currentByte;
        dataRbit <= currentByte[bitPos];
      end
    end
  end

  // ----------------------------------------
  // control and page registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auxReg <= mmxa_pkg::AUX_RESET; // see RQ15
      pageSelect <= mmxa_pkg::PAGE_RESET;
    end else begin
      if (writeLocal && hitAux) begin
        auxReg <= writeByte & mmxa_pkg::AUX_WRITABLE_MASK;
      end
      if (writeLocal && hitPage) begin
        // upper bits are dropped whatever software writes
        pageSelect <= writeByte[mmxa_pkg::PAGE_BITS-1:0]; // see RQ17 RQ18
      end
    end
  end

  assign pointerSelectBit = auxReg[mmxa_pkg::POINTER_SELECT_BIT]; // see RQ15

  // ----------------------------------------
  // dual data pointers
  // ----------------------------------------
  logic [15:0] pointerValue [0:POINTERS-1];

  genvar gi;
  generate
    for (gi = 0; gi < POINTERS; gi++) begin : g_pointer
      wire chosen;
      assign chosen = (gi == int'(pointerSelectBit)); // see RQ13
      mmxa_pointer_reg u_pointer (
        .clk(clk),
        .rst_n(rst_n),
        .loadWord(chosen && pointerLoad),
        .loadValue(pointerLoadValue),
        .writeLow(chosen && writeLocal && hitLow),
        .writeHigh(chosen && writeLocal && hitHigh),
        .byteValue(writeByte),
        .increment(chosen && pointerIncrement),
        .value(pointerValue[gi])
      ); // see RQ14 RQ16
    end
  endgenerate

  assign dataPointer = pointerValue[pointerSelectBit]; // see RQ13

  // ----------------------------------------
  // expanded RAM, served on chip only
  // ----------------------------------------
  logic [7:0] expRam [0:EXP_RAM_BYTES-1];
  wire [15:0] xAddr;
  wire xInRange;
  wire [mmxa_pkg::EXP_RAM_AW-1:0] xIndex;

  // paged form: page register high, R0/R1 low; same storage as pointer form
  assign xAddr = xPagedForm ? {5'b00000, pageSelect, xLowByte} // see RQ12 RQ19
                            : dataPointer; // see RQ14
  assign xInRange = ({16'h0000, xAddr} < 32'(EXP_RAM_BYTES)); // see RQ10
  assign xIndex = xAddr[mmxa_pkg::EXP_RAM_AW-1:0];

  always_ff @(posedge clk) begin
    if (xReq && xWe && xInRange) begin
      expRam[xIndex] <= xWdata; // see RQ10 RQ22
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xRvalid <= 1'b0;
      xRdata <= 8'h00;
    end else begin
      xRvalid <= xReq && !xWe; // see RQ11
      if (xReq && !xWe) begin
        xRdata <= xInRange ? expRam[xIndex] : mmxa_pkg::EXP_RAM_FILL; // see RQ22
      end
    end
  end

endmodule
`default_nettype wire

// file: hw/mmxa_pointer_reg.sv
`timescale 1ns/1ps
`default_nettype none
module mmxa_pointer_reg (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controls
  input wire logic loadWord,
  input wire logic [15:0] loadValue,
  input wire logic writeLow,
  input wire logic writeHigh,
  input wire logic [7:0] byteValue,
  input wire logic increment,
  // state
  output logic [15:0] value
);

  // ----------------------------------------
  // load beats byte write beats increment
  // ----------------------------------------
  logic [15:0] next_value;

  always_comb begin
    next_value = value;
    if (loadWord) begin
      next_value = loadValue;
    end else if (writeLow || writeHigh) begin
      if (writeLow) begin
        next_value[7:0] = byteValue;
      end
      if (writeHigh) begin
        next_value[15:8] = byteValue;
      end
    end else if (increment) begin
      next_value = value + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= mmxa_pkg::POINTER_RESET;
    end else begin
      value <= next_value;
    end
  end

endmodule
`default_nettype wire
